// ---- rtl/afd_pkg.sv ----
package afd_pkg;

  // Instruction field positions inside the decoded word.
  localparam int MOD_LSB = 0;
  localparam int ABC_LSB = 4;
  localparam int AE_BIT = 7;
  localparam int UM_BIT = 8;
  localparam int AMT_LSB = 9;

  // Modulo and branch-condition encodings.
  localparam logic [3:0] MOD_NONE = 4'hF;
  localparam logic [2:0] ABC_NONE = 3'h0;
  localparam logic [2:0] ABC_NONNEG = 3'h1;
  localparam logic [2:0] ABC_UNDEF = 3'h2;
  localparam logic [2:0] ABC_ZERO = 3'h3;
  localparam logic [2:0] ABC_NONPOS = 3'h4;
  localparam logic [2:0] ABC_NEG = 3'h5;
  localparam logic [2:0] ABC_NONZERO = 3'h6;
  localparam logic [2:0] ABC_NOOVF = 3'h7;

  // Right shifts are counted from this width.
  localparam logic [5:0] SHIFT_WIDTH = 6'h20;

  // Register byte addresses on the Avalon slave.
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] INSN_ADDR = 4'h4;
  localparam logic [3:0] STATUS_ADDR = 4'h8;

  // Control register fields and the control and instruction register reset values.
  localparam int CTRL_SW_BIT = 0;
  localparam int CTRL_KIND_LSB = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] INSN_RESET = 32'h0000_000F;

  // Status register fields.
  localparam int ST_MASK_LSB = 0;
  localparam int ST_WRAP_BIT = 16;
  localparam int ST_BR_BIT = 17;
  localparam int ST_AE_BIT = 18;
  localparam int ST_UM_BIT = 19;
  localparam int ST_LEFT_BIT = 20;
  localparam int ST_RIGHT_BIT = 21;
  localparam int ST_ROT_BIT = 22;
  localparam int ST_ARITH_BIT = 23;
  localparam int ST_AMT_LSB = 24;
  localparam int ST_VALID_BIT = 31;

  // Instruction class presented by the fetch stage.
  typedef enum logic [2:0] {
    AFD_NONE = 3'b000,
    AFD_LOGIC_REG = 3'b001,
    AFD_LOGIC_LEFT_IMM = 3'b010,
    AFD_LOGIC_RIGHT_IMM = 3'b011,
    AFD_ROT_REG = 3'b100,
    AFD_ROT_IMM = 3'b101,
    AFD_ARITH_REG = 3'b110,
    AFD_ARITH_IMM = 3'b111
  } afd_kind_e;

endpackage

// ---- rtl/afd_shift_dec.sv ----
`timescale 1ns/1ps
module afd_shift_dec
  import afd_pkg::*;
(
  input wire afd_kind_e kind,
  input wire logic [4:0] code,
  output logic left,
  output logic right,
  output logic rot,
  output logic arith,
  output logic [4:0] amount
);

  logic [5:0] right_amt;

  // Right amount counts down from the shift width; 10000 gives 16, 11111 gives 1.
  assign right_amt = SHIFT_WIDTH - {1'b0, code};

  // Logical forms share one table, the high code bit picking the direction.
  always_comb
  begin
    left = 1'b0;
    right = 1'b0;
    rot = 1'b0;
    arith = 1'b0;
    amount = 5'h00;
    case (kind)
      AFD_LOGIC_REG, AFD_LOGIC_LEFT_IMM, AFD_LOGIC_RIGHT_IMM:
      begin
        if (code[4])
        begin
          right = 1'b1;
          amount = right_amt[4:0];
        end
        else
        begin
          left = 1'b1;
          amount = code;
        end
      end
      AFD_ROT_REG, AFD_ROT_IMM:
      begin
        rot = 1'b1;
        amount = {1'b0, code[3:0]};
      end
      AFD_ARITH_REG:
      begin
        // Codes below 10000 have no right-shift meaning, so they shift by zero.
        arith = 1'b1;
        right = 1'b1;
        amount = code[4] ? right_amt[4:0] : 5'h00;
      end
      AFD_ARITH_IMM:
      begin
        arith = 1'b1;
        right = 1'b1;
        amount = {1'b0, code[3:0]};
      end
      default:
      begin
        amount = 5'h00;
      end
    endcase
  end

endmodule // afd_shift_dec

// ---- rtl/afd_top.sv ----
// Chosen here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
module afd_top
  import afd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic in_valid,
  input wire logic [31:0] in_insn,
  input wire afd_kind_e in_kind,
  input wire logic res_zero,
  input wire logic res_neg,
  input wire logic res_ovf,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic out_valid,
  output logic mod_wrap,
  output logic [15:0] mod_mask,
  output logic branch_take,
  output logic always_execute_bit,
  output logic memory_update_bit,
  output logic shift_left,
  output logic shift_right,
  output logic shift_rotate,
  output logic shift_arith,
  output logic [4:0] shift_amount
);

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [31:0] ctrl;
    logic [31:0] sw_insn;
    logic valid;
    logic wrap;
    logic [15:0] mask;
    logic br;
    logic ae;
    logic um;
    logic left;
    logic right;
    logic rot;
    logic arith;
    logic [4:0] amt;
  } afd_state_s;

  afd_state_s st;
  afd_state_s next_st;
  logic src_valid;
  logic [31:0] src_insn;
  afd_kind_e src_kind;
  logic [3:0] src_mod;
  logic [2:0] src_abc;
  logic dec_left;
  logic dec_right;
  logic dec_rot;
  logic dec_arith;
  logic [4:0] dec_amt;
  logic [31:0] status_word;

  // Merge written bytes into a register under the byte enables.
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        res[i*8 +: 8] = wd[i*8 +: 8];
    end
    return res;
  endfunction

  // Wrap mask for a modulo code: code k wraps at two to the k plus one.
  function automatic logic [15:0] wrap_mask(input logic [3:0] code);
    logic [16:0] one_hot;
    one_hot = 17'h00002 << code;
    return one_hot[15:0] - 16'h0001;
  endfunction

  // Branch decision from the condition code and the ALU result flags.
  function automatic logic branch_eval(input logic [2:0] abc, input logic z, input logic n, input logic v);
    logic take;
    take = 1'b0;
    case (abc)
      ABC_NONNEG: take = !n;
      ABC_ZERO: take = z;
      ABC_NONPOS: take = n || z;
      ABC_NEG: take = n;
      ABC_NONZERO: take = !z;
      ABC_NOOVF: take = !v;
      default: take = 1'b0;
    endcase
    return take;
  endfunction

  // Software can take over the decoder from its own instruction register for bring-up.
  assign src_valid = st.ctrl[CTRL_SW_BIT] ? 1'b1 : in_valid;
  assign src_insn = st.ctrl[CTRL_SW_BIT] ? st.sw_insn : in_insn;
  assign src_kind = st.ctrl[CTRL_SW_BIT] ? afd_kind_e'(st.ctrl[CTRL_KIND_LSB +: 3]) : in_kind;
  assign src_mod = src_insn[MOD_LSB +: 4];
  assign src_abc = src_insn[ABC_LSB +: 3];

  afd_shift_dec u_shift
  (
    .kind(src_kind),
    .code(src_insn[AMT_LSB +: 5]),
    .left(dec_left),
    .right(dec_right),
    .rot(dec_rot),
    .arith(dec_arith),
    .amount(dec_amt)
  );

  // Status shows the last registered decode.
  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[ST_MASK_LSB +: 16] = st.mask;
    status_word[ST_WRAP_BIT] = st.wrap;
    status_word[ST_BR_BIT] = st.br;
    status_word[ST_AE_BIT] = st.ae;
    status_word[ST_UM_BIT] = st.um;
    status_word[ST_LEFT_BIT] = st.left;
    status_word[ST_RIGHT_BIT] = st.right;
    status_word[ST_ROT_BIT] = st.rot;
    status_word[ST_ARITH_BIT] = st.arith;
    status_word[ST_AMT_LSB +: 5] = st.amt;
    status_word[ST_VALID_BIT] = st.valid;
  end

  // Next state: one decode stage plus a slave that answers on the second edge of a request.
  always_comb
  begin
    next_st = st;
    next_st.ack = (avs_read || avs_write) && !st.ack;
    if ((avs_read || avs_write) && !st.ack)
    begin
      // Read data are captured a cycle early so they stand when waitrequest drops.
      if (avs_address == CTRL_ADDR)
        next_st.rdata = st.ctrl;
      else if (avs_address == INSN_ADDR)
        next_st.rdata = st.sw_insn;
      else if (avs_address == STATUS_ADDR)
        next_st.rdata = status_word;
      else
        next_st.rdata = 32'h0000_0000;
    end
    if (avs_write && st.ack)
    begin
      if (avs_address == CTRL_ADDR)
        next_st.ctrl = be_merge(st.ctrl, avs_writedata, avs_byteenable) & 32'h0000_000F;
      else if (avs_address == INSN_ADDR)
        next_st.sw_insn = be_merge(st.sw_insn, avs_writedata, avs_byteenable);
    end
    next_st.valid = src_valid;
    if (src_valid)
    begin
      next_st.wrap = (src_mod != MOD_NONE);
      next_st.mask = (src_mod != MOD_NONE) ? wrap_mask(src_mod) : 16'hFFFF;
      next_st.br = branch_eval(src_abc, res_zero, res_neg, res_ovf);
      next_st.ae = src_insn[AE_BIT];
      next_st.um = src_insn[UM_BIT];
      next_st.left = dec_left;
      next_st.right = dec_right;
      next_st.rot = dec_rot;
      next_st.arith = dec_arith;
      next_st.amt = dec_amt;
    end
  end

  // Single state register; reset loads constants only.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= '0;
      st.ctrl <= CTRL_RESET;
      st.sw_insn <= INSN_RESET;
      st.mask <= 16'hFFFF;
    end
    else
      st <= next_st;
  end

  assign avs_waitrequest = (avs_read || avs_write) && !st.ack;
  assign avs_readdata = st.rdata;
  assign out_valid = st.valid;
  assign mod_wrap = st.wrap;
  assign mod_mask = st.mask;
  assign branch_take = st.br;
  assign always_execute_bit = st.ae;
  assign memory_update_bit = st.um;
  assign shift_left = st.left;
  assign shift_right = st.right;
  assign shift_rotate = st.rot;
  assign shift_arith = st.arith;
  assign shift_amount = st.amt;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  // Decode checks, each tied to the source fields one cycle earlier; the last one checks the bus handshake.
  mod_default_a: assert property (src_valid && src_mod == 4'hF |=> !mod_wrap && mod_mask == 16'hFFFF)
    else $error("modulo default code did not disable wrap");
  mod_top_a: assert property (src_valid && src_mod == 4'hE |=> mod_wrap && mod_mask == 16'h7FFF)
    else $error("modulo 32K mask wrong");
  br_zero_a: assert property (src_valid && src_abc == 3'h3 |=> branch_take == $past(res_zero))
    else $error("branch on zero wrong");
  br_nonpos_a: assert property (src_valid && src_abc == 3'h4 |=> branch_take == $past(res_neg || res_zero))
    else $error("branch on nonpositive wrong");
  br_undef_a: assert property (src_valid && (src_abc == 3'h2 || src_abc == 3'h0) |=> !branch_take)
    else $error("undefined or default code branched");
  ae_follow_a: assert property (src_valid |=> always_execute_bit == $past(src_insn[AE_BIT]))
    else $error("always execute bit not followed");
  um_follow_a: assert property (src_valid |=> memory_update_bit == $past(src_insn[UM_BIT]))
    else $error("memory update bit not followed");
  left_amt_a: assert property (src_valid && src_kind == AFD_LOGIC_LEFT_IMM && !src_insn[AMT_LSB + 4]
    |=> shift_left && shift_amount == $past(src_insn[AMT_LSB +: 5]))
    else $error("left shift amount wrong");
  right_amt_a: assert property (src_valid && src_kind == AFD_LOGIC_REG && src_insn[AMT_LSB +: 5] == 5'h10
    |=> shift_right && shift_amount == 5'h10)
    else $error("right shift by 16 wrong");
  rot_amt_a: assert property (src_valid && src_kind == AFD_ROT_IMM
    |=> shift_rotate && shift_amount == {1'b0, $past(src_insn[AMT_LSB +: 4])})
    else $error("rotate amount wrong");
  arith_imm_a: assert property (src_valid && src_kind == AFD_ARITH_IMM
    |=> shift_arith && shift_right && shift_amount == {1'b0, $past(src_insn[AMT_LSB +: 4])})
    else $error("arithmetic immediate amount wrong");
  arith_reg_a: assert property (src_valid && src_kind == AFD_ARITH_REG && src_insn[AMT_LSB +: 5] == 5'h1F
    |=> shift_arith && shift_amount == 5'h01)
    else $error("arithmetic register amount wrong");
  bus_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("slave held waitrequest too long");

  branch_cov: cover property (src_valid && src_abc == 3'h7 ##1 branch_take);
  rot_cov: cover property (src_valid && src_kind == AFD_ROT_REG ##1 shift_rotate);
  write_cov: cover property (avs_write && !avs_waitrequest && avs_address == CTRL_ADDR);
  sw_mode_cov: cover property (st.ctrl[CTRL_SW_BIT] ##1 out_valid);

endmodule // afd_top

// ---- tb/alu_field_decoder_tb_top.sv ----
`timescale 1ns/1ps
module alu_field_decoder_tb_top
  import afd_pkg::*;
;
  typedef struct packed {logic [28:0] exp; logic [28:0] care;} afd_note_s;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic in_valid = 1'b0;
  logic [31:0] in_insn = 32'h0;
  afd_kind_e in_kind = AFD_NONE;
  logic res_zero = 1'b0;
  logic res_neg = 1'b0;
  logic res_ovf = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic out_valid;
  logic mod_wrap;
  logic [15:0] mod_mask;
  logic branch_take;
  logic always_execute_bit;
  logic memory_update_bit;
  logic shift_left;
  logic shift_right;
  logic shift_rotate;
  logic shift_arith;
  logic [4:0] shift_amount;
  int n_mismatch = 0;
  int n_checks = 0;
  afd_note_s dq[$];
  logic [31:0] rq[$];
  afd_note_s nt;
  logic [28:0] sn;
  logic [31:0] w;
  afd_kind_e k;

  afd_top u_dut (.ref_clk(ref_clk), .rstn(rstn), .in_valid(in_valid), .in_insn(in_insn), .in_kind(in_kind),
    .res_zero(res_zero), .res_neg(res_neg), .res_ovf(res_ovf), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .out_valid(out_valid), .mod_wrap(mod_wrap),
    .mod_mask(mod_mask), .branch_take(branch_take), .always_execute_bit(always_execute_bit),
    .memory_update_bit(memory_update_bit), .shift_left(shift_left), .shift_right(shift_right),
    .shift_rotate(shift_rotate), .shift_arith(shift_arith), .shift_amount(shift_amount));

  // The clock runs at 20 MHz.
  always #25 ref_clk = ~ref_clk;

  // Reference decode: {wrap, mask, branch, ae, um, left, right, rot, arith, amount}.
  function automatic logic [28:0] model(input logic [31:0] x, input afd_kind_e kd, input logic [2:0] f);
    logic br;
    logic [3:0] sh;
    logic [4:0] amt;
    logic [4:0] a;
    a = x[13:9];
    case (x[6:4])
      ABC_NONNEG: br = !f[1];
      ABC_ZERO: br = f[2];
      ABC_NONPOS: br = f[1] | f[2];
      ABC_NEG: br = f[1];
      ABC_NONZERO: br = !f[2];
      ABC_NOOVF: br = !f[0];
      default: br = 1'b0;
    endcase
    sh = 4'h0;
    amt = a;
    case (kd)
      AFD_LOGIC_REG, AFD_LOGIC_LEFT_IMM, AFD_LOGIC_RIGHT_IMM: sh = a[4] ? 4'h4 : 4'h8;
      AFD_ROT_REG, AFD_ROT_IMM: sh = 4'h2;
      AFD_NONE: sh = 4'h0;
      default: sh = 4'h5;
    endcase
    if (a[4] && (sh == 4'h4 || kd == AFD_ARITH_REG))
      amt = 5'(SHIFT_WIDTH - {1'h0, a});
    else if (kd == AFD_ARITH_REG)
      amt = 5'h00;
    else if (sh != 4'h4 && sh != 4'h8)
      amt = {1'h0, a[3:0]};
    // A class with no shift decodes to no shift at all.
    if (kd == AFD_NONE)
      amt = 5'h00;
    return {x[3:0] != MOD_NONE, (x[3:0] == MOD_NONE) ? 16'hFFFF : 16'((17'h00001 << ({1'h0, x[3:0]} + 5'h01)) - 17'h00001),
      br, x[AE_BIT], x[UM_BIT], sh, amt};
  endfunction

  // Status word as software sees it after a decode.
  function automatic logic [31:0] stat(input logic [28:0] e);
    return {1'h1, 2'h0, e[4:0], e[5], e[6], e[7], e[8], e[9], e[10], e[11], e[28], e[27:12]};
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("mismatches %0d checks %0d", n_mismatch, n_checks);
    if (n_mismatch == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One Avalon transfer; the request stands until waitrequest is sampled low.
  task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_read <= rd;
    avs_write <= !rd;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    // A slave that never answers ends the run as a failure.
    if (n >= 50)
    begin
      n_mismatch++;
      end_sim();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    rq.push_back(exp);
    bus(1'b1, a, 32'h0, 4'hF);
  endtask

  // Present one instruction and note what the decode must show one cycle later.
  task automatic drive(input logic [31:0] x, input afd_kind_e kd, input logic [2:0] f, input logic v);
    afd_note_s e;
    @(posedge ref_clk);
    in_valid <= v;
    in_insn <= x;
    in_kind <= kd;
    {res_zero, res_neg, res_ovf} <= f;
    e.exp = model(x, kd, f);
    e.care = ~29'h0;
    if (v)
      dq.push_back(e);
  endtask

  // Outputs are compared against the oldest note whenever a result shows.
  always @(posedge ref_clk)
  begin
    if (rstn === 1'b1 && out_valid === 1'b1 && dq.size() > 0)
    begin
      nt = dq.pop_front();
      sn = {mod_wrap, mod_mask, branch_take, always_execute_bit, memory_update_bit, shift_left, shift_right,
        shift_rotate, shift_arith, shift_amount} & nt.care;
      nt.exp = nt.exp & nt.care;
      check("modulo", 32'(sn[28:12]), 32'(nt.exp[28:12]));
      check("branch", 32'(sn[11]), 32'(nt.exp[11]));
      check("always_execute", 32'(sn[10]), 32'(nt.exp[10]));
      check("memory_update", 32'(sn[9]), 32'(nt.exp[9]));
      check("shift", 32'(sn[8:0]), 32'(nt.exp[8:0]));
    end
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && rq.size() > 0)
      check("readdata", avs_readdata, rq.pop_front());
  end

  // A hang is cut short well beyond the several hundred cycles the tests need.
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    end_sim();
  end

  // Main sequence: register checks, software source, then table and random decodes.
  initial
  begin
    void'($urandom(32'hC21D));
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(CTRL_ADDR, CTRL_RESET);
    rd(INSN_ADDR, INSN_RESET);
    rd(STATUS_ADDR, 32'h0000_FFFF);
    bus(1'b0, 4'hC, 32'hFFFF_FFFF, 4'hF);
    rd(4'hC, 32'h0);
    bus(1'b0, INSN_ADDR, 32'h0000_00A5, 4'h1);
    rd(INSN_ADDR, 32'h0000_00A5);
    bus(1'b0, INSN_ADDR, 32'h0000_26E2, 4'hF);
    drive(32'h0, AFD_NONE, 3'h0, 1'b0);
    bus(1'b0, CTRL_ADDR, 32'hFFFF_FFF7, 4'hF);
    rd(CTRL_ADDR, 32'h0000_0007);
    rd(STATUS_ADDR, stat(model(32'h0000_26E2, AFD_LOGIC_RIGHT_IMM, 3'h0)));
    bus(1'b0, CTRL_ADDR, 32'h0, 4'hF);
    repeat (3) @(posedge ref_clk);
    // Back-to-back table sweep covers every modulo code, branch code and flag mix.
    for (int i = 0; i < 256; i++)
    begin
      w = {18'h0, 5'(i), 1'(i >> 1), 1'(i), 3'(i), 4'(i >> 4)};
      k = afd_kind_e'(3'h1 + 3'(i % 7));
      if (k == AFD_ROT_REG)
        w[13] = 1'b0;
      drive(w, k, 3'(i >> 3), 1'b1);
    end
    for (int i = 0; i < 300; i++)
    begin
      w = $urandom;
      k = afd_kind_e'(3'($urandom_range(7, 0)));
      if (k == AFD_ROT_REG)
        w[13] = 1'b0;
      drive(w, k, 3'($urandom), 1'($urandom));
    end
    drive(32'h0, AFD_NONE, 3'h0, 1'b0);
    repeat (4) @(posedge ref_clk);
    check("pending", 32'(dq.size()), 32'h0);
    end_sim();
  end
endmodule // alu_field_decoder_tb_top
